/* File: rtl/tcc_timer16.sv */
// 16-bit timer/counter: control registers, counter, compare, capture.
// Assumes a classic Wishbone master, 32-bit data, byte data in lane 0,
// and capture and count pins synchronous to clk.
//
// Behaviour
// - Resolution field 00 normal, 01/10/11 select 8, 9, 10-bit PWM.
// - Filter off: first qualifying sampled edge on capture pin captures.
// - Filter on: four equal clock samples at edge level before capture.
// - Edge select clear captures on falling edge, set on rising.
// - Control B bits 5 and 4 read zero, writes ignored.
// - Clear-on-match set, normal mode only: counter zeroed the cycle after match A.
// - Clear-on-match clear: compare matches leave the counter alone.
// - Match detected the clock cycle after counter equals compare.
// - Source 000 stops, 001 clock, 010-101 clock/8, 64, 256, 1024.
// - Source 110 counts pin falling edges, 111 rising edges.
// - Divided ticks come from the clock; stop code disables timer.
// - Counter, compares and capture share one 8-bit byte-hold latch.
// - High write goes to latch; low write loads all 16 bits.
// - Count/capture low read returns low, latches high; high read returns latch.
// - Counts up normally, up and down in PWM; always accessible.
// - After a preset, counting resumes from written value next tick.
// - PWM counts zero to TOP 255, 511 or 1023 and back down.
// - Capture flag sets together with the capture register copy.
// - External count pin sampled on rising clock edges.
// - Compare match sets its flag the cycle after the match.
//
// Implementation choice: register access over Wishbone.
`include "tcc_consts.svh"
`default_nettype none

module tcc_timer16 (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pins
   input wire logic capture_input_pin,
   input wire logic external_count_pin,
   // Compare events for the output pin logic
   output logic matchAEvent,
   output logic matchBEvent
);

   logic [7:0] ctrlA;
   logic [7:0] ctrlB;
   logic [7:0] byteHold;
   logic [15:0] countValue;
   tcc_pkg::tcc_dir_t dir;
   logic [15:0] matchValueA;
   logic [15:0] matchValueB;
   logic [15:0] captureValue;
   logic [7:0] flags;
   logic eqAPrev;
   logic eqBPrev;
   logic wrotePrev;
   logic [`TCC_FILT_LEN-1:0] capSamp;
   logic capLevel;
   logic ack;
   logic [7:0] datOut;

   logic [7:0] next_ctrlA;
   logic [7:0] next_ctrlB;
   logic [7:0] next_byteHold;
   logic [15:0] next_countValue;
   tcc_pkg::tcc_dir_t next_dir;
   logic [15:0] next_matchValueA;
   logic [15:0] next_matchValueB;
   logic [15:0] next_captureValue;
   logic [7:0] next_flags;
   logic next_eqAPrev;
   logic next_eqBPrev;
   logic next_wrotePrev;
   logic next_matchAEvent;
   logic next_matchBEvent;
   logic [`TCC_FILT_LEN-1:0] next_capSamp;
   logic next_capLevel;
   logic next_ack;
   logic [7:0] next_datOut;

   logic tick;
   logic req;
   logic wr;
   logic rd;
   logic [5:0] idx;
   logic [7:0] wbyte;
   tcc_pkg::tcc_res_t res;
   tcc_pkg::tcc_src_t src;
   logic pwm;
   logic [15:0] top;
   logic eqA;
   logic eqB;
   logic qual;
   logic capEdge;
   logic [7:0] flagSet;
   logic [7:0] flagClr;

   tcc_prescaler u_prescaler (
      .clk(clk),
      .reset(reset),
      .tickSel(src),
      .extPin(external_count_pin),
      .tick(tick)
   );

   assign req = wb_cyc_i & wb_stb_i & ~ack;
   assign wr = req & wb_we_i & wb_sel_i[0];
   assign rd = req & ~wb_we_i;
   assign idx = wb_adr_i[7:2];
   assign wbyte = wb_dat_i[7:0];
   assign res = tcc_pkg::tcc_res_t'(ctrlA[`TCC_CTRLA_RES_MSB:0]);
   assign src = tcc_pkg::tcc_src_t'(ctrlB[`TCC_CTRLB_SRC_MSB:0]);
   assign pwm = res != tcc_pkg::RES_NORMAL;
   assign eqA = countValue == matchValueA;
   assign eqB = countValue == matchValueB;

   always_comb begin
      case (res)
         tcc_pkg::RES_PWM8: top = `TCC_TOP_8;
         tcc_pkg::RES_PWM9: top = `TCC_TOP_9;
         tcc_pkg::RES_WAVEFORM_RES_SEL_LO: top = `TCC_TOP_10;
         default: top = `TCC_TOP_10;
      endcase
   end

   always_comb begin
      if (!ctrlB[`TCC_CTRLB_FILT_BIT]) begin
         qual = capSamp[0];
      end else if (&capSamp) begin
         qual = 1'b1;
      end else if (~|capSamp) begin
         qual = 1'b0;
      end else begin
         qual = capLevel;
      end
   end

   assign capEdge = (qual != capLevel) & (qual == ctrlB[`TCC_CTRLB_EDGE_BIT]);

   always_comb begin
      next_ctrlA = ctrlA;
      next_ctrlB = ctrlB;
      next_byteHold = byteHold;
      next_countValue = countValue;
      next_dir = dir;
      next_matchValueA = matchValueA;
      next_matchValueB = matchValueB;
      next_captureValue = captureValue;
      next_wrotePrev = 1'b0;
      next_ack = req;
      next_datOut = `TCC_RESET_BYTE;
      flagSet = `TCC_RESET_BYTE;
      flagClr = `TCC_RESET_BYTE;
      next_capSamp = {capSamp[`TCC_FILT_LEN-2:0], capture_input_pin};
      next_capLevel = qual;
      next_eqAPrev = eqA;
      next_eqBPrev = eqB;
      // match one cycle later
      // A preset that lands on the compare value is not a match
      next_matchAEvent = eqA & ~eqAPrev & ~wrotePrev;
      next_matchBEvent = eqB & ~eqBPrev & ~wrotePrev;

      if (tick) begin
         if (!pwm) begin
            next_countValue = countValue + 16'h0001;
         end else begin
            case (dir)
               tcc_pkg::DIR_UP: begin
                  if (countValue >= top) begin
                     next_dir = tcc_pkg::DIR_DOWN;
                     next_countValue = countValue - 16'h0001;
                  end else begin
                     next_countValue = countValue + 16'h0001;
                  end
               end
               tcc_pkg::DIR_DOWN: begin
                  if (countValue == `TCC_ZERO) begin
                     next_dir = tcc_pkg::DIR_UP;
                     next_countValue = countValue + 16'h0001;
                  end else begin
                     next_countValue = countValue - 16'h0001;
                  end
               end
               default: next_dir = tcc_pkg::DIR_UP;
            endcase
         end
      end

      if (matchAEvent && ctrlB[`TCC_CTRLB_CTC_BIT] && !pwm) begin
         next_countValue = `TCC_ZERO;
      end

      if (capEdge) begin
         next_captureValue = countValue;
         flagSet[`TCC_FLAG_CAP_BIT] = 1'b1;
      end
      flagSet[`TCC_FLAG_MA_BIT] = matchAEvent;
      flagSet[`TCC_FLAG_MB_BIT] = matchBEvent;

      if (wr) begin
         case (idx)
            `TCC_IDX_CNT_HI,
            `TCC_IDX_MA_HI,
            `TCC_IDX_MB_HI: next_byteHold = wbyte;
            `TCC_IDX_CNT_LO: begin
               next_countValue = {byteHold, wbyte};
               next_wrotePrev = 1'b1;
            end
            `TCC_IDX_MA_LO: begin
               next_matchValueA = {byteHold, wbyte};
               next_wrotePrev = 1'b1;
            end
            `TCC_IDX_MB_LO: begin
               next_matchValueB = {byteHold, wbyte};
               next_wrotePrev = 1'b1;
            end
            `TCC_IDX_CTRL_B: next_ctrlB = wbyte & `TCC_CTRLB_WMASK;
            `TCC_IDX_CTRL_A: next_ctrlA = wbyte & `TCC_CTRLA_WMASK;
            `TCC_IDX_FLAGS: flagClr = wbyte & `TCC_FLAGS_MASK;
            default: next_byteHold = byteHold;
         endcase
      end

      if (rd) begin
         case (idx)
            `TCC_IDX_CNT_LO: begin
               next_datOut = countValue[7:0];
               next_byteHold = countValue[15:8];
            end
            `TCC_IDX_CAP_LO: begin
               next_datOut = captureValue[7:0];
               next_byteHold = captureValue[15:8];
            end
            `TCC_IDX_CNT_HI,
            `TCC_IDX_CAP_HI: next_datOut = byteHold;
            `TCC_IDX_MA_LO: next_datOut = matchValueA[7:0];
            `TCC_IDX_MA_HI: next_datOut = matchValueA[15:8];
            `TCC_IDX_MB_LO: next_datOut = matchValueB[7:0];
            `TCC_IDX_MB_HI: next_datOut = matchValueB[15:8];
            `TCC_IDX_CTRL_B: next_datOut = ctrlB & `TCC_CTRLB_WMASK;
            `TCC_IDX_CTRL_A: next_datOut = ctrlA & `TCC_CTRLA_WMASK;
            `TCC_IDX_FLAGS: next_datOut = flags;
            default: next_datOut = `TCC_RESET_BYTE;
         endcase
      end

      // An event in the clearing cycle survives the clear
      next_flags = (flags & ~flagClr) | flagSet;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrlA <= `TCC_RESET_BYTE;
         ctrlB <= `TCC_RESET_BYTE;
         byteHold <= `TCC_RESET_BYTE;
         countValue <= `TCC_RESET_WORD;
         dir <= tcc_pkg::DIR_UP;
         matchValueA <= `TCC_RESET_WORD;
         matchValueB <= `TCC_RESET_WORD;
         captureValue <= `TCC_RESET_WORD;
         flags <= `TCC_RESET_BYTE;
         eqAPrev <= 1'b1;
         eqBPrev <= 1'b1;
         wrotePrev <= 1'b0;
         matchAEvent <= 1'b0;
         matchBEvent <= 1'b0;
         capSamp <= '0;
         capLevel <= 1'b0;
         ack <= 1'b0;
         datOut <= `TCC_RESET_BYTE;
      end else begin
         ctrlA <= next_ctrlA;
         ctrlB <= next_ctrlB;
         byteHold <= next_byteHold;
         countValue <= next_countValue;
         dir <= next_dir;
         matchValueA <= next_matchValueA;
         matchValueB <= next_matchValueB;
         captureValue <= next_captureValue;
         flags <= next_flags;
         eqAPrev <= next_eqAPrev;
         eqBPrev <= next_eqBPrev;
         wrotePrev <= next_wrotePrev;
         matchAEvent <= next_matchAEvent;
         matchBEvent <= next_matchBEvent;
         capSamp <= next_capSamp;
         capLevel <= next_capLevel;
         ack <= next_ack;
         datOut <= next_datOut;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = {24'h000000, datOut};

endmodule // tcc_timer16

`default_nettype wire

/* File: rtl/tcc_consts.svh */
// Offsets, field positions, reset values and counts of the 16-bit timer.
// Included by the timer and prescaler modules; definitions only.
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// Register indices; byte address on the bus is four times the index
`define TCC_IDX_CAP_LO 6'h26
`define TCC_IDX_CAP_HI 6'h27
`define TCC_IDX_MB_LO 6'h28
`define TCC_IDX_MB_HI 6'h29
`define TCC_IDX_MA_LO 6'h2a
`define TCC_IDX_MA_HI 6'h2b
`define TCC_IDX_CNT_LO 6'h2c
`define TCC_IDX_CNT_HI 6'h2d
`define TCC_IDX_CTRL_B 6'h2e
`define TCC_IDX_CTRL_A 6'h2f
`define TCC_IDX_FLAGS 6'h30

// Control register B fields
`define TCC_CTRLB_FILT_BIT 7
`define TCC_CTRLB_EDGE_BIT 6
`define TCC_CTRLB_CTC_BIT 3
`define TCC_CTRLB_SRC_MSB 2
`define TCC_CTRLB_WMASK 8'hcf

// Control register A fields
`define TCC_CTRLA_RES_MSB 1
`define TCC_CTRLA_WMASK 8'hf3

// Status flag bits, write one to clear
`define TCC_FLAG_CAP_BIT 0
`define TCC_FLAG_MA_BIT 1
`define TCC_FLAG_MB_BIT 2
`define TCC_FLAGS_MASK 8'h07

`define TCC_RESET_BYTE 8'h00
`define TCC_RESET_WORD 16'h0000

// Turning points of the up/down count
`define TCC_TOP_8 16'h00ff
`define TCC_TOP_9 16'h01ff
`define TCC_TOP_10 16'h03ff
`define TCC_ZERO 16'h0000

// Capture filter length in clock samples
`define TCC_FILT_LEN 4

// Prescaler divisors and width
`define TCC_PRE_W 10
`define TCC_DIV_8 10'h007
`define TCC_DIV_64 10'h03f
`define TCC_DIV_256 10'h0ff
`define TCC_DIV_1024 10'h3ff

`endif

/* File: rtl/tcc_pkg.sv */
// Types shared by the timer modules.
// Assumes tcc_consts.svh is on the include path.
`default_nettype none

package tcc_pkg;

   // Resolution field of control register A
   typedef enum logic [1:0] {
      RES_NORMAL = 2'b00,
      RES_PWM8 = 2'b01,
      RES_PWM9 = 2'b10,
      RES_WAVEFORM_RES_SEL_LO = 2'b11
   } tcc_res_t;

   // Tick source field of control register B
   typedef enum logic [2:0] {
      SRC_STOP = 3'b000,
      SRC_CK = 3'b001,
      SRC_CK8 = 3'b010,
      SRC_CK64 = 3'b011,
      SRC_CK256 = 3'b100,
      SRC_CK1024 = 3'b101,
      SRC_PIN_FALL = 3'b110,
      SRC_PIN_RISE = 3'b111
   } tcc_src_t;

   // Count direction state
   typedef enum logic [1:0] {
      DIR_UP = 2'b01,
      DIR_DOWN = 2'b10
   } tcc_dir_t;

endpackage

`default_nettype wire

/* File: rtl/tcc_prescaler.sv */
// Tick source: free-running prescaler and external count pin edge detect.
// Assumes the count pin is synchronous to clk and changes at most once
// per clock period.
`include "tcc_consts.svh"
`default_nettype none

module tcc_prescaler (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Selection and pin
   input wire tcc_pkg::tcc_src_t tickSel,
   input wire logic extPin,
   // Counter enable
   output logic tick
);

   logic [`TCC_PRE_W-1:0] preCnt;
   logic [`TCC_PRE_W-1:0] next_preCnt;
   logic extSamp;
   logic extPrev;
   logic next_extSamp;
   logic next_extPrev;
   logic [3:0] divTap;
   logic [`TCC_PRE_W-1:0] divMask [4];

   assign divMask[0] = `TCC_DIV_8;
   assign divMask[1] = `TCC_DIV_64;
   assign divMask[2] = `TCC_DIV_256;
   assign divMask[3] = `TCC_DIV_1024;

   generate
      for (genvar i = 0; i < 4; i++) begin : g_tap
         assign divTap[i] = (preCnt & divMask[i]) == divMask[i];
      end
   endgenerate

   always_comb begin
      next_preCnt = preCnt + `TCC_PRE_W'(1);
      next_extSamp = extPin;
      next_extPrev = extSamp;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         preCnt <= '0;
         extSamp <= 1'b0;
         extPrev <= 1'b0;
      end else begin
         preCnt <= next_preCnt;
         extSamp <= next_extSamp;
         extPrev <= next_extPrev;
      end
   end

   always_comb begin
      case (tickSel)
         tcc_pkg::SRC_STOP: tick = 1'b0;
         tcc_pkg::SRC_CK: tick = 1'b1;
         tcc_pkg::SRC_CK8: tick = divTap[0];
         tcc_pkg::SRC_CK64: tick = divTap[1];
         tcc_pkg::SRC_CK256: tick = divTap[2];
         tcc_pkg::SRC_CK1024: tick = divTap[3];
         tcc_pkg::SRC_PIN_FALL: tick = extPrev & ~extSamp;
         tcc_pkg::SRC_PIN_RISE: tick = ~extPrev & extSamp;
         default: tick = 1'b0;
      endcase
   end

endmodule // tcc_prescaler

`default_nettype wire

/* File: dv/tcc_timer16_sva.sv */
// Checker of bus answers and match-event shape of tcc_timer16.
// Sees only the top ports; attached by the bind at the foot.
`default_nettype none

module tcc_timer16_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Events
   input wire logic matchAEvent
);
   timeunit 1ns;
   timeprecision 1ps;
   wire req = wb_cyc_i & wb_stb_i & !wb_ack_o;
   wire rdReq = req & !wb_we_i;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_ack_next: assert property (req |=> wb_ack_o)
      else $error("bus request left without ack");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_data_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read lanes not zero");
   a_ctlb_rsvd: assert property (rdReq && wb_adr_i[7:2] == 6'h2e
      |=> wb_dat_o[5:4] == 2'b00)
      else $error("control B reserved bits not zero");
   a_ctla_gap: assert property (rdReq && wb_adr_i[7:2] == 6'h2f
      |=> wb_dat_o[3:2] == 2'b00)
      else $error("control A reserved bits not zero");
   a_unmapped_zero: assert property (rdReq && wb_adr_i[7:2] == 6'h3f
      |=> wb_ack_o && wb_dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   a_match_pulse: assert property (matchAEvent |=> !matchAEvent)
      else $error("match event longer than one cycle");
endmodule // tcc_timer16_sva

bind tcc_timer16 tcc_timer16_sva u_tcc_timer16_sva (.clk(clk),
   .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .matchAEvent(matchAEvent));

`default_nettype wire

/* File: dv/tcc_pin_model.sv */
// Far-side pin model: capture pin and external count pin.
// Assumes requests arrive by non-blocking assignment after clk edges.
`default_nettype none

module tcc_pin_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Requests from the bench
   input wire logic capLevel,
   input wire logic cntFlip,
   // Pins
   output logic capturePin,
   output logic countPin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic next_countPin;

   always_comb begin
      next_countPin = countPin ^ cntFlip;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         countPin <= 1'b0;
         capturePin <= 1'b0;
      end else begin
         countPin <= next_countPin;
         capturePin <= capLevel;
      end
   end
endmodule // tcc_pin_model

`default_nettype wire

/* File: dv/tcc_timer16_bench.sv */
// Self-checking bench of tcc_timer16 over classic Wishbone.
// Assumes the pin model and the bound checker are compiled alongside.
`default_nettype none

module tcc_timer16_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic capLevel = 1'b0;
   logic cntFlip = 1'b0;
   logic [31:0] rdat;
   logic ack, capPin, cntPin, mA, mB;
   logic [7:0] rb;
   logic [15:0] v;
   int n_fail = 0;
   int checks_done = 0;
   int nMatch = 0;
   int nMatchB = 0;

   always #2 clk = ~clk;
   always @(posedge clk) if (mA === 1'b1) nMatch++;
   always @(posedge clk) if (mB === 1'b1) nMatchB++;

   tcc_pin_model u_tcc_pin_model (.clk(clk), .reset(reset),
      .capLevel(capLevel), .cntFlip(cntFlip), .capturePin(capPin),
      .countPin(cntPin));
   tcc_timer16 u_tcc_timer16 (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .capture_input_pin(capPin), .external_count_pin(cntPin),
      .matchAEvent(mA), .matchBEvent(mB));

   task automatic tally_and_finish;
      $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rng(input string nm, input logic [15:0] lo,
                      input logic [15:0] hi, input logic [15:0] g);
      checks_done++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         n_fail++;
         $display("[FAIL] %s expected %h..%h seen %h", nm, lo, hi, g);
      end
   endtask

   // Request held until the ack edge, then released for a cycle
   task automatic wb(input logic w, input logic [5:0] i,
                     input logic [7:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      wdat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      rb = rdat[7:0];
      cyc <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      wb(1'b1, i, d);
   endtask

   task automatic rd(input logic [5:0] i);
      wb(1'b0, i, 8'h00);
   endtask

   task automatic setCnt(input logic [15:0] x);
      wr(6'h2d, x[15:8]);
      wr(6'h2c, x[7:0]);
   endtask

   task automatic getCnt;
      rd(6'h2c);
      v[7:0] = rb;
      rd(6'h2d);
      v[15:8] = rb;
   endtask

   task automatic t_regs;
      rd(6'h2e);
      chk("ctrlB reset", 16'h0000, rb);
      getCnt;
      chk("count reset", 16'h0000, v);
      wr(6'h2e, 8'hff);
      rd(6'h2e);
      chk("ctrlB rsvd", 16'h00cf, rb);
      wr(6'h2f, 8'hff);
      rd(6'h2f);
      chk("ctrlA gap", 16'h00f3, rb);
      rd(6'h3f);
      chk("unmapped", 16'h0000, rb);
      wr(6'h2f, 8'h00);
      wr(6'h2e, 8'h00);
   endtask

   task automatic t_latch;
      setCnt(16'h1234);
      getCnt;
      chk("count word", 16'h1234, v);
      wr(6'h2d, 8'hab);
      wr(6'h2a, 8'h07);
      rd(6'h2b);
      chk("shared latch", 16'h00ab, rb);
   endtask

   task automatic t_src;
      int dv [6] = '{0, 1, 8, 64, 256, 1024};
      for (int s = 0; s < 6; s++) begin
         setCnt(16'h0000);
         wr(6'h2e, 8'(s));
         repeat (3 * dv[s] + 1) @(posedge clk);
         wr(6'h2e, 8'h00);
         getCnt;
         if (s == 0) chk("stopped", 16'h0000, v);
         else rng("divided", 16'd3, 16'(4 + 6 / dv[s]), v);
      end
   endtask

   task automatic t_pin;
      for (int s = 6; s < 8; s++) begin
         setCnt(16'h0000);
         wr(6'h2e, 8'(s));
         repeat (6) begin
            cntFlip <= 1'b1;
            @(posedge clk);
            cntFlip <= 1'b0;
            repeat (3) @(posedge clk);
         end
         wr(6'h2e, 8'h00);
         getCnt;
         chk("pin edges", 16'h0003, v);
      end
   endtask

   task automatic t_ctc;
      wr(6'h2b, 8'h00);
      wr(6'h2a, 8'h05);
      setCnt(16'h0000);
      wr(6'h30, 8'h07);
      nMatch = 0;
      nMatchB = 0;
      wr(6'h2e, 8'h09);
      repeat (50) @(posedge clk);
      wr(6'h2e, 8'h00);
      getCnt;
      rng("clear on A", 16'd0, 16'd6, v);
      rng("match events", 16'd5, 16'd9, 16'(nMatch));
      rng("match B events", 16'd5, 16'd9, 16'(nMatchB));
      rd(6'h30);
      chk("match flags", 16'h0006, rb & 8'h06);
      setCnt(16'h0000);
      wr(6'h2e, 8'h01);
      repeat (50) @(posedge clk);
      wr(6'h2e, 8'h00);
      getCnt;
      rng("no clear", 16'd50, 16'd60, v);
      setCnt(16'hfffe);
      wr(6'h2e, 8'h01);
      wr(6'h2e, 8'h00);
      getCnt;
      rng("wrap", 16'h0000, 16'h0008, v);
   endtask

   task automatic t_run;
      wr(6'h2e, 8'h01);
      setCnt(16'h1000);
      rd(6'h2c);
      repeat (300) @(posedge clk);
      rd(6'h2d);
      chk("hi snapshot", 16'h0010, rb);
      wr(6'h2e, 8'h00);
      setCnt(16'h1000);
      wr(6'h2e, 8'h01);
      wr(6'h2e, 8'h00);
      getCnt;
      rng("resume", 16'h1001, 16'h100a, v);
   endtask

   task automatic t_pwm;
      logic [15:0] top;
      for (int r = 1; r < 4; r++) begin
         top = (r == 1) ? 16'h00ff : (r == 2) ? 16'h01ff : 16'h03ff;
         wr(6'h2f, 8'(r));
         // Direction survives a preset, so settle it upward from zero
         setCnt(16'h0000);
         wr(6'h2e, 8'h01);
         wr(6'h2e, 8'h00);
         getCnt;
         chk("pwm zero turn", 16'h0003, v);
         setCnt(top - 16'h0010);
         wr(6'h2e, 8'h01);
         repeat (40) @(posedge clk);
         wr(6'h2e, 8'h00);
         getCnt;
         rng("pwm turn", top - 16'h0024, top - 16'h0010, v);
      end
      wr(6'h2f, 8'h00);
   endtask

   task automatic t_cap;
      wr(6'h30, 8'h07);
      setCnt(16'h1234);
      wr(6'h2e, 8'h40);
      capLevel <= 1'b1;
      repeat (4) @(posedge clk);
      rd(6'h30);
      chk("cap flag", 16'h0001, rb & 8'h01);
      rd(6'h26);
      chk("cap rise lo", 16'h0034, rb);
      rd(6'h27);
      chk("cap rise hi", 16'h0012, rb);
      setCnt(16'h5678);
      wr(6'h2e, 8'h00);
      capLevel <= 1'b0;
      repeat (4) @(posedge clk);
      rd(6'h26);
      chk("cap fall", 16'h0078, rb);
      wr(6'h30, 8'h01);
      setCnt(16'h0abc);
      wr(6'h2e, 8'hc0);
      capLevel <= 1'b1;
      repeat (3) @(posedge clk);
      capLevel <= 1'b0;
      repeat (8) @(posedge clk);
      rd(6'h30);
      chk("short pulse", 16'h0000, rb & 8'h01);
      capLevel <= 1'b1;
      repeat (8) @(posedge clk);
      wr(6'h26, 8'hff);
      rd(6'h26);
      chk("filtered cap", 16'h00bc, rb);
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      tally_and_finish;
   end

   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_regs;
      t_latch;
      t_src;
      t_pin;
      t_ctc;
      t_run;
      t_pwm;
      t_cap;
      tally_and_finish;
   end
endmodule // tcc_timer16_bench

`default_nettype wire
